// File: src/mpfps_pkg.sv
package mpfps_pkg;

    // Identification code layout.
    localparam int VID_W = 6;
    localparam logic [4:0] VID_SHUTDOWN_TOP = 5'h1f;

    // Regulation target, carried in microvolts.
    localparam int TARGET_W = 21;
    localparam int OFFSET_MV = 19;
    localparam int UV_PER_MV = 1000;
    localparam logic [TARGET_W-1:0] TARGET_RESET = 21'h000000;

    // Phase generator geometry.
    localparam int PHASES = 4;
    localparam int SW_PERIOD_CYC = 120;
    localparam int ON_CYC = 12;

    // Cycles the strap pins settle after reset before they are sampled.
    localparam int STRAP_SETTLE_CYC = 4;
    localparam int SETTLE_W = 3;

    // Gate output positions.
    localparam int GATE1_IDX = 0;
    localparam int GATE2_IDX = 1;
    localparam int GATE3_IDX = 2;
    localparam int GATE4_IDX = 3;

    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } mpfps_mode_e;

    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_OV_LATCH = 3'b011,
        ST_OC_LATCH = 3'b100
    } mpfps_state_e;

    typedef struct packed {
        logic pos;
        logic neg;
    } mpfps_sense_s;

    typedef struct packed {
        mpfps_sense_s ph4;
        mpfps_sense_s ph3;
        mpfps_sense_s ph2;
        mpfps_sense_s ph1;
    } mpfps_strap_s;

    typedef struct packed {
        logic enable;
        logic total_overcurrent;
        logic ref_undervoltage;
        logic overvoltage_guard;
        logic supply_lockout;
    } mpfps_fault_s;

endpackage : mpfps_pkg

// File: src/mpfps_phase_gen.sv
`timescale 1ns/1ns
module mpfps_phase_gen #(
    parameter int PERIOD_CYC = mpfps_pkg::SW_PERIOD_CYC,
    parameter int ON_CYC = mpfps_pkg::ON_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Control.
    input wire logic run,
    input wire mpfps_pkg::mpfps_mode_e mode,
    // Gate drive.
    output logic [mpfps_pkg::PHASES-1:0] phase_gate_out
);

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] ON_LEN = CW'(ON_CYC);

    logic [CW-1:0] cnt;
    logic [1:0] slot;
    logic [CW-1:0] slot_len;
    logic [1:0] last_slot;
    logic [1:0] gate_idx;

    // Slot length is the period split evenly over the active phases.
    function automatic logic [CW-1:0] slot_cycles(
        input mpfps_pkg::mpfps_mode_e m);
        case (m)
            mpfps_pkg::PH_ONE: slot_cycles = CW'(PERIOD_CYC);
            mpfps_pkg::PH_TWO: slot_cycles = CW'(PERIOD_CYC / 2);
            mpfps_pkg::PH_THREE: slot_cycles = CW'(PERIOD_CYC / 3);
            default: slot_cycles = CW'(PERIOD_CYC / 4);
        endcase
    endfunction : slot_cycles

    // Maps a slot of the rotation onto the gate it fires.
    function automatic logic [1:0] slot_gate(
        input mpfps_pkg::mpfps_mode_e m, input logic [1:0] s);
        case (m)
            mpfps_pkg::PH_ONE: slot_gate = 2'(mpfps_pkg::GATE2_IDX);
            mpfps_pkg::PH_TWO: slot_gate = s[0] ?
                2'(mpfps_pkg::GATE4_IDX) : 2'(mpfps_pkg::GATE2_IDX);
            default: slot_gate = s;
        endcase
    endfunction : slot_gate

    assign slot_len = slot_cycles(mode);
    assign last_slot = 2'(mode);
    assign gate_idx = slot_gate(mode, slot);

    ////////////////////////////////////////////////////////////////////////
    // spacing follows count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            slot <= 2'h0;
        end else if (!run) begin
            cnt <= '0;
            slot <= 2'h0;
        end else if (cnt == slot_len - CW'(1)) begin
            cnt <= '0;
            slot <= (slot == last_slot) ? 2'h0 : slot + 2'h1;
        end else begin
            cnt <= cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_gate_out <= '0;
        end else begin
            phase_gate_out <= '0;
            if (run && cnt < ON_LEN) begin
                phase_gate_out[gate_idx] <= 1'b1;
            end
        end
    end

endmodule : mpfps_phase_gen

// File: src/mpfps_top.sv
`timescale 1ns/1ns
module mpfps_top #(
    parameter int VID_BASE_UV = 1600000,
    parameter int VID_STEP_UV = 12500,
    parameter int PERIOD_CYC = mpfps_pkg::SW_PERIOD_CYC,
    parameter int ON_CYC = mpfps_pkg::ON_CYC
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // Processor identification code.
    input wire logic [mpfps_pkg::VID_W-1:0] VOLTAGE_ID_CODE,
    // Enable, supply and fault comparators.
    input wire mpfps_pkg::mpfps_fault_s FAULT_IN,
    // Output voltage comparison and supply-good sense.
    input wire logic OUTPUT_IN_RANGE,
    input wire logic SUPPLY_GOOD_SENSE,
    // Current-sense pin strapping levels.
    input wire mpfps_pkg::mpfps_strap_s STRAP_IN,
    // Gate drive and driver enable.
    output logic [mpfps_pkg::PHASES-1:0] PHASE_GATE_OUT,
    output logic DRIVER_ENABLE_OUT,
    // Status.
    output logic SUPPLY_GOOD_OUT,
    output logic [mpfps_pkg::TARGET_W-1:0] REG_TARGET_UV,
    output mpfps_pkg::mpfps_mode_e PHASE_MODE_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release.

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    localparam logic [mpfps_pkg::SETTLE_W-1:0] SETTLE_LAST =
        mpfps_pkg::SETTLE_W'(mpfps_pkg::STRAP_SETTLE_CYC - 1);

    mpfps_pkg::mpfps_state_e state;
    mpfps_pkg::mpfps_state_e next_state;
    mpfps_pkg::mpfps_mode_e mode;
    logic [mpfps_pkg::SETTLE_W-1:0] settle_cnt;
    logic strap_done;
    logic reserved_code;
    logic hard_fault;
    logic gates_run;
    logic next_drv_en;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Tied pair at one level counts as a strap of that level.
    function automatic logic pair_low(input mpfps_pkg::mpfps_sense_s p);
        pair_low = !p.pos && !p.neg;
    endfunction : pair_low

    function automatic logic pair_high(input mpfps_pkg::mpfps_sense_s p);
        pair_high = p.pos && p.neg;
    endfunction : pair_high

    // Order matters: single phase also grounds phases one and three.
    function automatic mpfps_pkg::mpfps_mode_e strap_decode(
        input mpfps_pkg::mpfps_strap_s s);
        if (pair_high(s.ph4)) begin
            strap_decode = mpfps_pkg::PH_THREE;
        end else if (pair_low(s.ph1) && pair_low(s.ph3) &&
                     pair_low(s.ph4)) begin
            strap_decode = mpfps_pkg::PH_ONE;
        end else if (pair_low(s.ph1) && pair_low(s.ph3)) begin
            strap_decode = mpfps_pkg::PH_TWO;
        end else begin
            strap_decode = mpfps_pkg::PH_FOUR;
        end
    endfunction : strap_decode

    // Linear code table; the coded value less the fixed offset.
    function automatic logic [mpfps_pkg::TARGET_W-1:0] target_of(
        input logic [mpfps_pkg::VID_W-1:0] code);
        int uv;
        uv = VID_BASE_UV - int'(code) * VID_STEP_UV -
             mpfps_pkg::OFFSET_MV * mpfps_pkg::UV_PER_MV;
        if (uv < 0) begin
            uv = 0;
        end
        target_of = mpfps_pkg::TARGET_W'(uv);
    endfunction : target_of

    ////////////////////////////////////////////////////////////////////////
    // Strap sampling.

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= '0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            if (settle_cnt == SETTLE_LAST) begin
                strap_done <= 1'b1;
            end else begin
                settle_cnt <= settle_cnt + mpfps_pkg::SETTLE_W'(1);
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode <= mpfps_pkg::PH_FOUR;
        end else if (!strap_done && settle_cnt == SETTLE_LAST) begin
            mode <= strap_decode(STRAP_IN);
        end
    end

    assign PHASE_MODE_OUT = mode;

    ////////////////////////////////////////////////////////////////////////
    // Identification code.

    assign reserved_code =
        VOLTAGE_ID_CODE[mpfps_pkg::VID_W-1:1] == mpfps_pkg::VID_SHUTDOWN_TOP;

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_TARGET_UV <= mpfps_pkg::TARGET_RESET;
        end else begin
            REG_TARGET_UV <= target_of(VOLTAGE_ID_CODE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault sequencer.

    assign hard_fault =
        FAULT_IN.total_overcurrent || FAULT_IN.ref_undervoltage;

    always_comb begin
        next_state = state;
        case (state)
            mpfps_pkg::ST_POR: begin
                if (!FAULT_IN.supply_lockout) begin
                    next_state = mpfps_pkg::ST_IDLE;
                end
            end
            mpfps_pkg::ST_IDLE: begin
                if (FAULT_IN.supply_lockout) begin
                    next_state = mpfps_pkg::ST_POR;
                end else if (hard_fault) begin
                    next_state = mpfps_pkg::ST_OC_LATCH;
                end else if (FAULT_IN.enable) begin
                    next_state = mpfps_pkg::ST_RUN;
                end
            end
            mpfps_pkg::ST_RUN: begin
                if (FAULT_IN.supply_lockout) begin
                    next_state = mpfps_pkg::ST_POR;
                end else if (hard_fault) begin
                    next_state = mpfps_pkg::ST_OC_LATCH;
                end else if (!FAULT_IN.enable) begin
                    next_state = mpfps_pkg::ST_IDLE;
                end
            end
            mpfps_pkg::ST_OV_LATCH: next_state = mpfps_pkg::ST_OV_LATCH;
            mpfps_pkg::ST_OC_LATCH: next_state = mpfps_pkg::ST_OC_LATCH;
            default: next_state = mpfps_pkg::ST_POR;
        endcase
        if (!FAULT_IN.supply_lockout && FAULT_IN.overvoltage_guard) begin
            next_state = mpfps_pkg::ST_OV_LATCH;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= mpfps_pkg::ST_POR;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Driver enable.

    always_comb begin
        case (next_state)
            mpfps_pkg::ST_POR: next_drv_en = 1'b1;
            mpfps_pkg::ST_OV_LATCH: next_drv_en = 1'b1;
            mpfps_pkg::ST_RUN: next_drv_en = !reserved_code;
            default: next_drv_en = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            DRIVER_ENABLE_OUT <= 1'b1;
        end else begin
            DRIVER_ENABLE_OUT <= next_drv_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Supply good.

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            SUPPLY_GOOD_OUT <= 1'b0;
        end else begin
            SUPPLY_GOOD_OUT <= OUTPUT_IN_RANGE && SUPPLY_GOOD_SENSE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase generator.

    assign gates_run = state == mpfps_pkg::ST_RUN && next_state ==
        mpfps_pkg::ST_RUN && !reserved_code && strap_done;

    mpfps_phase_gen #(
        .PERIOD_CYC(PERIOD_CYC),
        .ON_CYC(ON_CYC)
    ) u_phase_gen (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .run(gates_run),
        .mode(mode),
        .phase_gate_out(PHASE_GATE_OUT)
    );

endmodule : mpfps_top

// File: verif/mpfps_top_sva.sv
`timescale 1ns/1ns
module mpfps_top_sva #(
    parameter int VID_BASE_UV = 1600000,
    parameter int VID_STEP_UV = 12500,
    parameter int PERIOD_CYC = mpfps_pkg::SW_PERIOD_CYC
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // Inputs.
    input wire logic [mpfps_pkg::VID_W-1:0] VOLTAGE_ID_CODE,
    input wire mpfps_pkg::mpfps_fault_s FAULT_IN,
    input wire logic OUTPUT_IN_RANGE,
    input wire logic SUPPLY_GOOD_SENSE,
    // Outputs.
    input wire logic [mpfps_pkg::PHASES-1:0] PHASE_GATE_OUT,
    input wire logic DRIVER_ENABLE_OUT,
    input wire logic SUPPLY_GOOD_OUT,
    input wire logic [mpfps_pkg::TARGET_W-1:0] REG_TARGET_UV,
    input wire mpfps_pkg::mpfps_mode_e PHASE_MODE_OUT
);
    localparam int SLOT4 = PERIOD_CYC / 4;
    localparam int SLOT3 = PERIOD_CYC / 3;
    localparam int SLOT2 = PERIOD_CYC / 2;
    localparam int OFS = mpfps_pkg::OFFSET_MV * mpfps_pkg::UV_PER_MV;
    logic [3:0] up;
    logic ready;
    logic off;
    // Edges since release, so the reset synchroniser has settled.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            up <= 4'h0;
        end else if (up != 4'hf) begin
            up <= up + 4'h1;
        end
    end
    assign ready = up >= 4'h4;
    assign off = PHASE_GATE_OUT == 4'h0;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    ////////////////////////////////////////////////////////////////////////
    property p_tgt;
        ready |-> int'(REG_TARGET_UV) ==
            VID_BASE_UV - VID_STEP_UV * int'($past(VOLTAGE_ID_CODE)) - OFS;
    endproperty
    a_tgt: assert property (p_tgt) else $error("target wrong");
    property p_shut;
        ready && VOLTAGE_ID_CODE[5:1] == mpfps_pkg::VID_SHUTDOWN_TOP |=> off;
    endproperty
    a_shut: assert property (p_shut) else $error("gates on");
    property p_rise;
        ready && $rose(DRIVER_ENABLE_OUT) |-> $past(FAULT_IN.enable) ||
            $past(FAULT_IN.overvoltage_guard) || $past(FAULT_IN.supply_lockout);
    endproperty
    a_rise: assert property (p_rise) else $error("enable rose");
    property p_gde;
        !off |-> DRIVER_ENABLE_OUT || $past(DRIVER_ENABLE_OUT);
    endproperty
    a_gde: assert property (p_gde) else $error("gate without enable");
    property p_good;
        ready |-> SUPPLY_GOOD_OUT == ($past(OUTPUT_IN_RANGE) &&
            $past(SUPPLY_GOOD_SENSE));
    endproperty
    a_good: assert property (p_good) else $error("good wrong");
    property p_four;
        PHASE_MODE_OUT == mpfps_pkg::PH_FOUR && $rose(PHASE_GATE_OUT[0])
            |-> ##SLOT4 ($rose(PHASE_GATE_OUT[1]) || off);
    endproperty
    a_four: assert property (p_four) else $error("four spacing");
    property p_three;
        PHASE_MODE_OUT == mpfps_pkg::PH_THREE && $rose(PHASE_GATE_OUT[2])
            |-> ##SLOT3 ($rose(PHASE_GATE_OUT[0]) || off);
    endproperty
    a_three: assert property (p_three) else $error("three spacing");
    property p_two;
        PHASE_MODE_OUT == mpfps_pkg::PH_TWO && $rose(PHASE_GATE_OUT[1])
            |-> ##SLOT2 ($rose(PHASE_GATE_OUT[3]) || off);
    endproperty
    a_two: assert property (p_two) else $error("two spacing");
    property p_one;
        PHASE_MODE_OUT == mpfps_pkg::PH_ONE |-> (PHASE_GATE_OUT & 4'hd) == 0;
    endproperty
    a_one: assert property (p_one) else $error("single gate");
    property p_hot;
        $onehot0(PHASE_GATE_OUT);
    endproperty
    a_hot: assert property (p_hot) else $error("gates overlap");
    property p_ov;
        ready && FAULT_IN.overvoltage_guard && !FAULT_IN.supply_lockout
            |-> ##2 (DRIVER_ENABLE_OUT && off) [*8];
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage latch");
    property p_mode;
        up == 4'hf |-> $stable(PHASE_MODE_OUT);
    endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
endmodule : mpfps_top_sva
bind mpfps_top mpfps_top_sva #(
    .VID_BASE_UV(VID_BASE_UV),
    .VID_STEP_UV(VID_STEP_UV),
    .PERIOD_CYC(PERIOD_CYC)
) u_sva (
    .REF_CLK(REF_CLK),
    .ARST_N(ARST_N),
    .VOLTAGE_ID_CODE(VOLTAGE_ID_CODE),
    .FAULT_IN(FAULT_IN),
    .OUTPUT_IN_RANGE(OUTPUT_IN_RANGE),
    .SUPPLY_GOOD_SENSE(SUPPLY_GOOD_SENSE),
    .PHASE_GATE_OUT(PHASE_GATE_OUT),
    .DRIVER_ENABLE_OUT(DRIVER_ENABLE_OUT),
    .SUPPLY_GOOD_OUT(SUPPLY_GOOD_OUT),
    .REG_TARGET_UV(REG_TARGET_UV),
    .PHASE_MODE_OUT(PHASE_MODE_OUT)
);

// File: verif/mpfps_vid_model.sv
`timescale 1ns/1ns
module mpfps_vid_model (
    // Processor request.
    input wire logic drive,
    input wire logic [mpfps_pkg::VID_W-1:0] code,
    // Lines at the controller.
    output logic [mpfps_pkg::VID_W-1:0] vid
);
    // Released lines sit at the pull-up level, which reads as shutdown.
    assign vid = drive ? code : 6'h3f;
endmodule : mpfps_vid_model

// File: verif/multiphase_fault_phase_sequencer_bench.sv
`timescale 1ns/1ns
module multiphase_fault_phase_sequencer_bench;
    localparam int P = 24;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic drv = 1'b0;
    logic [5:0] req = 6'h00;
    logic in_rng = 1'b0;
    logic sg = 1'b0;
    logic prev_good = 1'b0;
    mpfps_pkg::mpfps_fault_s fault = 5'h01;
    mpfps_pkg::mpfps_strap_s strap = 8'h55;
    logic [5:0] vid;
    logic [3:0] gate;
    logic de;
    logic sgo;
    logic [20:0] tgt;
    mpfps_pkg::mpfps_mode_e mode;
    int n_mismatch = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    always @(posedge clk) {in_rng, sg} <= 2'($urandom);
    always @(posedge clk) prev_good <= in_rng & sg;
    mpfps_vid_model u_vid (.drive(drv), .code(req), .vid(vid));
    mpfps_top #(.PERIOD_CYC(P), .ON_CYC(3)) DUT (
        .REF_CLK(clk), .ARST_N(arst_n), .VOLTAGE_ID_CODE(vid),
        .FAULT_IN(fault), .OUTPUT_IN_RANGE(in_rng),
        .SUPPLY_GOOD_SENSE(sg), .STRAP_IN(strap), .PHASE_GATE_OUT(gate),
        .DRIVER_ENABLE_OUT(de), .SUPPLY_GOOD_OUT(sgo),
        .REG_TARGET_UV(tgt), .PHASE_MODE_OUT(mode));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task summarize();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    task wn(input int n);
        repeat (n) @(negedge clk);
    endtask : wn
    function int exp_gate(input int m, input int t);
        int s;
        s = (m == 3) ? P / 4 : (m == 2) ? P / 3 : (m == 1) ? P / 2 : P;
        if (t % s >= 3) return 0;
        if (m >= 2) return 1 << (t % P / s);
        return (t % P / s) ? 8 : 2;
    endfunction : exp_gate
    task wait_gate();
        int i;
        @(negedge clk);
        for (i = 0; i < 200 && gate === 4'h0; i++) @(negedge clk);
        chk(gate !== 4'h0, 1);
    endtask : wait_gate
    task quiet(input logic exp_de);
        int t;
        for (t = 0; t < 30; t++) begin
            chk(gate, 0);
            @(negedge clk);
        end
        chk(de, exp_de);
    endtask : quiet
    ////////////////////////////////////////////////////////////////////////
    task run_mode(input int m, input logic [7:0] st);
        int t;
        int c;
        @(posedge clk);
        strap <= st;
        fault <= 5'h01;
        drv <= 1'b0;
        arst_n <= 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge clk);
        fault <= 5'h03;
        wn(2);
        chk(de, 1);
        @(posedge clk);
        fault <= 5'h00;
        drv <= 1'b1;
        wn(3);
        chk(de, 0);
        chk(mode, m);
        @(posedge clk);
        strap <= 8'($urandom);
        fault <= 5'h10;
        wn(2);
        chk(mode, m);
        wait_gate();
        for (t = 0; t < 2 * P; t++) begin
            chk(gate, exp_gate(m, t));
            @(negedge clk);
        end
        chk(de, 1);
        for (t = 0; t < 6; t++) begin
            c = (t == 0) ? 0 : (t == 1) ? 61 : (t < 4) ? 62 + t - 2
                : $urandom_range(61, 0);
            @(posedge clk);
            req <= 6'(c);
            wn(2);
            chk(tgt, 1600000 - 12500 * c - 19000);
            if (c > 61) quiet(1'b0);
        end
        wait_gate();
        @(posedge clk);
        fault <= 5'h00;
        wn(2);
        quiet(1'b0);
        @(posedge clk);
        fault <= 5'h10;
        wait_gate();
        @(posedge clk);
        fault <= 5'h10 | ((m == 0) ? 5'h08 : (m == 2) ? 5'h04 : 5'h02);
        @(posedge clk);
        fault <= 5'h10;
        wn(3);
        quiet(m[0]);
        chk(sgo, prev_good);
    endtask : run_mode
    initial begin
        void'($urandom(44763));
        run_mode(3, 8'h55);
        run_mode(2, 8'hd5);
        run_mode(1, 8'h4c);
        run_mode(0, 8'h0c);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule : multiphase_fault_phase_sequencer_bench
